// >>> rtl/gpos_map.svh
// Register offsets and reset values of the output set/clear alias block
`ifndef GPOS_MAP_SVH
`define GPOS_MAP_SVH

`define GPOS_OFS_OUTPUT_DIRECT     12'h504
`define GPOS_OFS_OUTPUT_SET_ALIAS  12'h508
`define GPOS_OFS_OUTPUT_CLR_ALIAS  12'h50C
`define GPOS_LATCH_RESET           32'h00000000
`define GPOS_RESP_OKAY             2'h0
`define GPOS_RESP_SLVERR           2'h2

`endif

// >>> rtl/gpos_pkg.sv
// Types shared by the output set/clear alias block
package gpos_pkg;

  // Decoded target of a register access
  typedef enum logic [1:0] {
    GPOS_SEL_NONE,
    GPOS_SEL_SET,
    GPOS_SEL_CLR
  } gpos_sel_t;

  // One AXI4-Lite response word
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } gpos_rsp_t;

endpackage

// >>> rtl/gpos_alias.sv
// Output latch with atomic set and clear alias registers on AXI4-Lite
// Bus timing
//   Address and data are taken in either order or at the same edge.
//   The write is applied one edge after the later of the two is taken;
//   the latch and the write response change at that same edge.
//   The response stands until bready is seen high; only then may a new
//   address or data word be taken.
//   A read captures the latch at the edge that takes its address; the
//   data stands from the next cycle until rready is seen high.
//   Reads and writes run side by side; a read taken at the edge that
//   applies a write returns the latch as it was before that write.
//
// Clock enable
//   While clk_en is low no state moves and every ready and valid output
//   reads low, so the bus simply stalls. Reset still acts.
//   pin_out and read data keep their values through the freeze.
//
// Limitations
//   One write and one read are tracked at a time.
//   Byte strobes mask which latch bits a set or a clear may touch.
//   Offsets other than the two aliases answer with a slave error, have
//   no effect, and read back as zero.
//   Address bits above the decoded width are not looked at, so the
//   block repeats through any larger window it is placed in.
//   pin_out follows the latch directly; pad drivers and direction
//   control live outside this block.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`include "gpos_map.svh"
`timescale 1ns/10ps
`default_nettype none

module gpos_alias #(
  parameter int ADDR_W = 12,
  parameter int PINS   = 32
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [PINS-1:0]        pin_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by read and write paths
  // Low two address bits are ignored; each register is one aligned word
  function automatic gpos_pkg::gpos_sel_t decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [11:0] a;
    a = 12'(addr) & 12'hFFC;
    if (a == `GPOS_OFS_OUTPUT_SET_ALIAS) begin
      decode = gpos_pkg::GPOS_SEL_SET;
    end else if (a == `GPOS_OFS_OUTPUT_CLR_ALIAS) begin
      decode = gpos_pkg::GPOS_SEL_CLR;
    end else begin
      decode = gpos_pkg::GPOS_SEL_NONE;
    end
  endfunction

  // Expand byte strobes into a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    strb_mask = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [PINS-1:0]         latch_q;
  logic                    aw_held_q;
  logic [ADDR_W-1:0]       awaddr_q;
  logic                    w_held_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  gpos_pkg::gpos_rsp_t     rsp_q;
  logic                    wr_fire;
  gpos_pkg::gpos_sel_t     wr_sel;
  logic [PINS-1:0]         wr_bits;

  // Channels accept while no response is pending; every ready and valid
  // is held low while clk_en is low, so no transfer completes against
  // frozen state and no response is seen twice
  assign s_axi_awready = clk_en & ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = clk_en & ~w_held_q & ~bvalid_q;
  assign s_axi_arready = clk_en & ~rvalid_q;
  assign s_axi_bvalid  = clk_en & bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = clk_en & rvalid_q;
  assign s_axi_rdata   = rsp_q.data;
  assign s_axi_rresp   = rsp_q.resp;
  assign pin_out       = latch_q;

  // Write happens once both address and data are held
  // and no earlier response is still waiting to be taken
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_sel  = decode(awaddr_q);
  assign wr_bits = PINS'(wdata_q & strb_mask(wstrb_q));

  ////////////////////////////////////////////////////////////////////////////
  // Capture write address
  // Held until the matching data is also held, then released together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  // Capture write data and strobes
  // Strobes are kept with the data so a partial write masks its bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Output latch updated by set or clear alias writes; only one write is
  // applied per edge, so a set and a clear never meet in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= PINS'(`GPOS_LATCH_RESET);
    end else if (clk_en && wr_fire) begin
      if (wr_sel == gpos_pkg::GPOS_SEL_SET) begin
        latch_q <= latch_q | wr_bits;
      end else if (wr_sel == gpos_pkg::GPOS_SEL_CLR) begin
        latch_q <= latch_q & ~wr_bits;
      end
    end
  end

  // Write response, error for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `GPOS_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        // Unmapped offsets are answered but leave the latch alone
        if (wr_sel == gpos_pkg::GPOS_SEL_NONE) begin
          bresp_q <= `GPOS_RESP_SLVERR;
        end else begin
          bresp_q <= `GPOS_RESP_OKAY;
        end
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read path returns latch for either alias, no side effect
  // Latch is sampled at the address edge; a write applied at that same
  // edge shows in the next read, not this one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rsp_q    <= '0;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        if (decode(s_axi_araddr) == gpos_pkg::GPOS_SEL_NONE) begin
          rsp_q.data <= 32'h00000000;
          rsp_q.resp <= `GPOS_RESP_SLVERR;
        end else begin
          rsp_q.data <= 32'(latch_q);
          rsp_q.resp <= `GPOS_RESP_OKAY;
        end
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// >>> dv/gpos_alias_props.sv
// Concurrent checks on the alias block's bus and latch ports
`timescale 1ns/10ps
`default_nettype none

module gpos_alias_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] pin_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);

  ////////////////////////////////////////////////////////////////////////
  // Address and data both taken in one edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_new;
    $rose(s_axi_rvalid);
  endsequence

  a_write_answer: assert property (
    wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write got no response");
  a_latch_hold: assert property (
    !$rose(s_axi_bvalid) |-> $stable(pin_out))
    else $error("latch moved without a write");
  a_one_way: assert property (
    (pin_out & ~$past(pin_out)) == 32'h0 ||
    (~pin_out & $past(pin_out)) == 32'h0)
    else $error("latch set and cleared");
  a_read_latch: assert property (
    rd_new ##0 s_axi_rresp == 2'h0 |-> s_axi_rdata == $past(pin_out))
    else $error("read data differs from latch");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read got no answer");
  a_aw_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("address taken while response pending");
  a_ar_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_bad_zero: assert property (
    rd_new ##0 s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
    else $error("unmapped read data not zero");
  a_reset_clear: assert property (
    $rose(aresetn) |-> pin_out == 32'h0)
    else $error("latch not cleared by reset");
  a_freeze_bus: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !clk_en |-> !s_axi_awready && !s_axi_wready && !s_axi_arready &&
    !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus moved while clock enable low");
  a_freeze_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !$past(clk_en) |-> $stable(pin_out))
    else $error("latch moved while clock enable low");
endmodule

bind gpos_alias gpos_alias_props u_props (.*);

`default_nettype wire

// >>> dv/testbench.sv
// Register-level test of the output set and clear alias block
`include "gpos_map.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, br = 0, rr = 0;
  logic        clk_en = 1'h1;
  logic [3:0]  ws     = 4'hF;
  localparam logic [11:0] ofs_set = `GPOS_OFS_OUTPUT_SET_ALIAS;
  localparam logic [11:0] ofs_clr = `GPOS_OFS_OUTPUT_CLR_ALIAS;
  localparam logic [11:0] ofs_dir = `GPOS_OFS_OUTPUT_DIRECT;
  logic awr, wr_rdy, bv, arr, rv;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_d, pin;
  logic [1:0]  bresp, rresp;
  int          compares = 0, miscompares = 0;

  gpos_alias u_gpos_alias (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .pin_out(pin));

  // Clock at 50 MHz
  always #10 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and closing
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er,
                    logic [31:0] ep);
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    forever begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
      if (bv) break;
    end
    br <= 0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    chk("pin_out", pin, ep);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] ed, logic [1:0] er);
    @(posedge aclk);
    ara <= a; arv <= 1; rr <= 1;
    forever begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rr <= 0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    chk("rdata", rd_d, ed);
  endtask
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #100000;
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("reset", pin, `GPOS_LATCH_RESET);
    wr(ofs_set, 32'h80000001, 2'h0, 32'h80000001);
    wr(ofs_set, 32'h000000F0, 2'h0, 32'h800000F1);
    wr(ofs_clr, 32'h80000010, 2'h0, 32'h000000E1);
    rd(ofs_set, 32'h000000E1, 2'h0);
    rd(ofs_clr, 32'h000000E1, 2'h0);
    wr(ofs_clr, 32'h0, 2'h0, 32'h000000E1);
    wr(ofs_dir, 32'hFFFFFFFF, 2'h2, 32'h000000E1);
    rd(ofs_dir, 32'h0, 2'h2);
    // Byte strobes limit which bits a set may touch
    ws <= 4'h2;
    wr(ofs_set, 32'hFFFFFFFF, 2'h0, 32'h0000FFE1);
    ws <= 4'hF;
    // Frozen enable: the write waits and the latch holds
    clk_en <= 1'h0;
    fork
      wr(ofs_clr, 32'h0000FF00, 2'h0, 32'h000000E1);
      begin
        repeat (4) @(posedge aclk);
        chk("frozen", pin, 32'h0000FFE1);
        chk("awready", {31'h0, awr}, 32'h0);
        clk_en <= 1'h1;
      end
    join
    // Reset in mid-run clears the latch again
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("rerun", pin, `GPOS_LATCH_RESET);
    rd(ofs_set, 32'h0, 2'h0);
    wr(ofs_set, 32'h0000000C, 2'h0, 32'h0000000C);
    wr(ofs_clr, 32'hFFFFFFFF, 2'h0, 32'h0);
    test_done();
  end
endmodule

`default_nettype wire
